// file: design/dmach_pkg.sv
// constants, register map and types for the single dma channel core
// What this block does
// - out-of-range ram: drop writes, reads return zero
// - unimplemented address raises trap, sets status
// - block completes after count plus one
// - count means elements, bytes or words alike
// - control bit 14 selects byte size
// - post-increment by two words, one bytes
// - direction clear: peripheral read, ram write
// - direction set: ram read, peripheral write
// - half bit picks half or full interrupt
// - half interrupt at rounded-up half, none at end
// - half cleared mid-block still gives full interrupt
// - interrupt pulses the flag for one cycle only
// - reset addressing mode is post-increment 00
// - active start register reads latest address while enabled, value kept
// - dual-ported ram direct, ordinary ram via arbiter
// - primary and secondary starts, ping-pong switching
// - mode 11 is one-shot with ping-pong
// - manual trigger forces one element transfer
// - addressing mode 01 keeps the address fixed
// - mode 0 continuous across blocks
// - requests served only when channel enabled
package dmach_pkg;
    localparam int          DMACH_AW            = 16;
    localparam int          DMACH_DW            = 16;
    localparam int          DMACH_RA            = 3;
    // register indices on the plain register port
    localparam logic [2:0]  DMACH_REG_CTRL      = 3'h0;
    localparam logic [2:0]  DMACH_REG_STA       = 3'h1;
    localparam logic [2:0]  DMACH_REG_STB       = 3'h2;
    localparam logic [2:0]  DMACH_REG_PAD       = 3'h3;
    localparam logic [2:0]  DMACH_REG_CNT       = 3'h4;
    localparam logic [2:0]  DMACH_REG_STAT      = 3'h5;
    localparam logic [2:0]  DMACH_REG_FORCE     = 3'h6;
    // channel_control field positions
    localparam int          DMACH_B_EN          = 15;
    localparam int          DMACH_B_SIZE        = 14;
    localparam int          DMACH_B_DIR         = 13;
    localparam int          DMACH_B_HALF        = 12;
    localparam int          DMACH_B_AM_LO       = 4;
    localparam int          DMACH_B_MD_LO       = 0;
    localparam logic [15:0] DMACH_CTRL_RST      = 16'h0000;
    localparam logic [15:0] DMACH_CTRL_MASK     = 16'hF033;
    // status bits
    localparam int          DMACH_S_ERR         = 0;
    localparam int          DMACH_S_PPB         = 1;
    localparam int          DMACH_S_BUSY        = 2;
    // addressing and operating modes
    localparam logic [1:0]  DMACH_AM_POSTINC    = 2'h0;
    localparam logic [1:0]  DMACH_AM_FIXED      = 2'h1;
    localparam logic [1:0]  DMACH_MD_CONT       = 2'h0;
    localparam logic [1:0]  DMACH_MD_ONESHOT    = 2'h1;
    localparam logic [1:0]  DMACH_MD_CONT_PP    = 2'h2;
    localparam logic [1:0]  DMACH_MD_ONESHOT_PP = 2'h3;
    localparam logic [15:0] DMACH_INC_WORD      = 16'h0002;
    localparam logic [15:0] DMACH_INC_BYTE      = 16'h0001;
    localparam logic [15:0] DMACH_ONE           = 16'h0001;
    // default memory map: dual-ported window, ram top, implemented top
    localparam logic [15:0] DMACH_DP_LO         = 16'hD000;
    localparam logic [15:0] DMACH_DP_HI         = 16'hDFFF;
    localparam logic [15:0] DMACH_RAM_LO        = 16'h1000;
    localparam logic [15:0] DMACH_RAM_HI        = 16'hDFFF;
    localparam logic [15:0] DMACH_IMPL_HI       = 16'hDFFF;

    typedef enum logic [4:0] {
        DMACH_IDLE  = 5'h01,
        DMACH_RD    = 5'h02,
        DMACH_RWAIT = 5'h04,
        DMACH_WR    = 5'h08,
        DMACH_WWAIT = 5'h10
    } dmach_state_t;
endpackage

// file: design/dmach_core.sv
// one dma channel: registers, request handling, ram and peripheral moves
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
module dmach_core
    import dmach_pkg::*;
#(
    parameter logic [15:0] DP_LO   = DMACH_DP_LO,
    parameter logic [15:0] DP_HI   = DMACH_DP_HI,
    parameter logic [15:0] RAM_LO  = DMACH_RAM_LO,
    parameter logic [15:0] RAM_HI  = DMACH_RAM_HI,
    parameter logic [15:0] IMPL_HI = DMACH_IMPL_HI
) (
    input  wire logic                ref_clk,
    input  wire logic                nrst,
    input  wire logic [DMACH_RA-1:0] reg_addr,
    input  wire logic [15:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [15:0]         reg_rdata,
    input  wire logic                periph_req,
    output logic                     periph_rd,
    output logic                     periph_wr,
    output logic      [15:0]         periph_addr,
    output logic      [15:0]         periph_wdata,
    input  wire logic [15:0]         periph_rdata,
    output logic                     dpram_rd,
    output logic                     dpram_wr,
    output logic                     arb_rd,
    output logic                     arb_wr,
    input  wire logic                arb_gnt,
    output logic      [15:0]         mem_addr,
    output logic      [15:0]         mem_wdata,
    output logic                     mem_byte,
    input  wire logic [15:0]         dpram_rdata,
    input  wire logic [15:0]         arb_rdata,
    output logic                     channel_interrupt_flag,
    output logic                     addr_error_trap
);
    // programmed registers
    logic [15:0]  channel_control_r, channel_control_nxt;
    logic [15:0]  primary_start_address_r, primary_start_address_nxt;
    logic [15:0]  secondary_start_address_r, secondary_start_address_nxt;
    logic [15:0]  peripheral_address_r, peripheral_address_nxt;
    logic [15:0]  transfer_count_r, transfer_count_nxt;
    logic         address_error_status_r, address_error_status_nxt;
    // transfer state
    dmach_state_t state_r, state_nxt;
    logic [15:0]  ptr_r, ptr_nxt;
    logic [15:0]  last_addr_r, last_addr_nxt;
    logic [15:0]  done_r, done_nxt;
    logic         use_b_r, use_b_nxt;
    logic         half_sent_r, half_sent_nxt;
    logic         pend_r, pend_nxt;
    logic         force_r, force_nxt;
    logic [15:0]  data_r, data_nxt;
    logic [15:0]  rdata_r, rdata_nxt;
    logic         irq_r, irq_nxt;
    logic         trap_r, trap_nxt;
    logic         p_rd_r, p_rd_nxt, p_wr_r, p_wr_nxt;
    logic         d_rd_r, d_rd_nxt, d_wr_r, d_wr_nxt;
    logic         a_rd_r, a_rd_nxt, a_wr_r, a_wr_nxt;
    logic [15:0]  maddr_r, maddr_nxt, mwdata_r, mwdata_nxt;

    // decoded control fields
    logic         en, size_b, dir, half;
    logic [1:0]   addressing_mode_field, opmode;
    logic [15:0]  half_pt, inc, base;
    logic         in_dp, in_ram, impl;
    always_comb begin
        en      = channel_control_r[DMACH_B_EN];
        size_b  = channel_control_r[DMACH_B_SIZE];
        dir     = channel_control_r[DMACH_B_DIR];
        half    = channel_control_r[DMACH_B_HALF];
        addressing_mode_field   = channel_control_r[DMACH_B_AM_LO +: 2];
        opmode  = channel_control_r[DMACH_B_MD_LO +: 2];
        // rounded-up half of count+1
        half_pt = 16'((17'(transfer_count_r) + 17'h2) >> 1);
        inc     = size_b ? DMACH_INC_BYTE : DMACH_INC_WORD;
        base    = use_b_r ? secondary_start_address_r : primary_start_address_r;
        in_dp   = (ptr_r >= DP_LO) && (ptr_r <= DP_HI);
        in_ram  = (ptr_r >= RAM_LO) && (ptr_r <= RAM_HI);
        impl    = ptr_r <= IMPL_HI;
    end

    // register writes, sequencing and interrupts
    always_comb begin
        channel_control_nxt         = channel_control_r;
        primary_start_address_nxt   = primary_start_address_r;
        secondary_start_address_nxt = secondary_start_address_r;
        peripheral_address_nxt      = peripheral_address_r;
        transfer_count_nxt          = transfer_count_r;
        address_error_status_nxt    = address_error_status_r;
        state_nxt     = state_r;
        ptr_nxt       = ptr_r;
        last_addr_nxt = last_addr_r;
        done_nxt      = done_r;
        use_b_nxt     = use_b_r;
        half_sent_nxt = half_sent_r;
        pend_nxt      = pend_r | periph_req;
        force_nxt     = force_r;
        data_nxt      = data_r;
        irq_nxt       = 1'b0;
        trap_nxt      = 1'b0;
        p_rd_nxt = 1'b0;
        p_wr_nxt = 1'b0;
        d_rd_nxt = 1'b0;
        d_wr_nxt = 1'b0;
        a_rd_nxt = a_rd_r & ~arb_gnt;
        a_wr_nxt = a_wr_r & ~arb_gnt;
        maddr_nxt  = maddr_r;
        mwdata_nxt = mwdata_r;
        case (state_r)
            DMACH_IDLE: begin
                if (en && (pend_r || force_r)) begin
                    pend_nxt  = periph_req;
                    force_nxt = 1'b0;
                    state_nxt = DMACH_RD;
                end
            end
            DMACH_RD: begin
                trap_nxt                 = !impl;
                address_error_status_nxt = address_error_status_r | !impl;
                // no memory strobe when out of range
                maddr_nxt = ptr_r;
                p_rd_nxt  = !dir;
                d_rd_nxt  = dir && in_ram && in_dp;
                a_rd_nxt  = dir && in_ram && !in_dp;
                state_nxt = DMACH_RWAIT;
            end
            DMACH_RWAIT: begin
                // arbiter reads may stall until granted
                if (!a_rd_r || arb_gnt) begin
                    data_nxt  = !dir ? periph_rdata : d_rd_r ? dpram_rdata : a_rd_r ? arb_rdata : 16'h0000;
                    state_nxt = DMACH_WR;
                end
            end
            DMACH_WR: begin
                if (dir) begin
                    p_wr_nxt  = 1'b1;
                end else if (in_ram) begin
                    maddr_nxt  = ptr_r;
                    mwdata_nxt = data_r;
                    d_wr_nxt   = in_dp;
                    a_wr_nxt   = !in_dp;
                end
                // out-of-range ram write dropped
                state_nxt = DMACH_WWAIT;
            end
            DMACH_WWAIT: begin
                if (!a_wr_r || arb_gnt) begin
                    last_addr_nxt = ptr_r;
                    if (addressing_mode_field == DMACH_AM_POSTINC) begin
                        ptr_nxt = ptr_r + inc;
                    end
                    // fixed mode keeps the pointer
                    done_nxt  = done_r + DMACH_ONE;
                    state_nxt = DMACH_IDLE;
                    if (half && !half_sent_r && (done_r + DMACH_ONE == half_pt)) begin
                        irq_nxt       = 1'b1;
                        half_sent_nxt = 1'b1;
                    end
                    if (done_r == transfer_count_r) begin
                        // full interrupt unless half still selected
                        irq_nxt       = !half || (half_pt == DMACH_ONE && !half_sent_r);
                        done_nxt      = 16'h0000;
                        half_sent_nxt = 1'b0;
                        if (opmode[1]) begin
                            use_b_nxt = !use_b_r;
                        end
                        ptr_nxt = (opmode[1] ^ use_b_r) ? secondary_start_address_r
                                                        : primary_start_address_r;
                        if (opmode[0]) begin
                            channel_control_nxt[DMACH_B_EN] = 1'b0; // one-shot ends
                        end
                        // continuous keeps the enable set
                    end
                end
            end
            default: state_nxt = DMACH_IDLE;
        endcase
        // software writes override the sequencer
        if (reg_wr) begin
            if (reg_addr == DMACH_REG_CTRL) begin
                channel_control_nxt = reg_wdata & DMACH_CTRL_MASK;
                if (reg_wdata[DMACH_B_EN] && !en) begin
                    done_nxt      = 16'h0000;
                    half_sent_nxt = 1'b0;
                    ptr_nxt       = base;
                end
            end else if (reg_addr == DMACH_REG_STA) begin
                primary_start_address_nxt = reg_wdata;
                if (!en) begin
                    ptr_nxt = reg_wdata;
                end
            end else if (reg_addr == DMACH_REG_STB) begin
                secondary_start_address_nxt = reg_wdata;
            end else if (reg_addr == DMACH_REG_PAD) begin
                peripheral_address_nxt = reg_wdata;
            end else if (reg_addr == DMACH_REG_CNT) begin
                transfer_count_nxt = reg_wdata;
            end else if (reg_addr == DMACH_REG_STAT) begin
                // write one to clear; a same-cycle error wins
                if (reg_wdata[DMACH_S_ERR] && !trap_nxt) begin
                    address_error_status_nxt = 1'b0;
                end
            end else if (reg_addr == DMACH_REG_FORCE) begin
                force_nxt = 1'b1;
            end
        end
    end

    // read data, one cycle after the strobe
    always_comb begin
        rdata_nxt = 16'h0000;
        if (reg_rd) begin
            if (reg_addr == DMACH_REG_CTRL) begin
                rdata_nxt = channel_control_r;
            end else if (reg_addr == DMACH_REG_STA) begin
                rdata_nxt = (!use_b_r && en) ? last_addr_r : primary_start_address_r;
            end else if (reg_addr == DMACH_REG_STB) begin
                rdata_nxt = (use_b_r && en) ? last_addr_r : secondary_start_address_r;
            end else if (reg_addr == DMACH_REG_PAD) begin
                rdata_nxt = peripheral_address_r;
            end else if (reg_addr == DMACH_REG_CNT) begin
                rdata_nxt = transfer_count_r;
            end else if (reg_addr == DMACH_REG_STAT) begin
                rdata_nxt[DMACH_S_ERR]  = address_error_status_r;
                rdata_nxt[DMACH_S_PPB]  = use_b_r;
                rdata_nxt[DMACH_S_BUSY] = state_r != DMACH_IDLE;
            end
        end
    end

    // all state registered here; control resets to post-increment, mode 0
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            channel_control_r         <= DMACH_CTRL_RST;
            primary_start_address_r   <= 16'h0000;
            secondary_start_address_r <= 16'h0000;
            peripheral_address_r      <= 16'h0000;
            transfer_count_r          <= 16'h0000;
            address_error_status_r    <= 1'b0;
            state_r     <= DMACH_IDLE;
            ptr_r       <= 16'h0000;
            last_addr_r <= 16'h0000;
            done_r      <= 16'h0000;
            use_b_r     <= 1'b0;
            half_sent_r <= 1'b0;
            pend_r      <= 1'b0;
            force_r     <= 1'b0;
            data_r      <= 16'h0000;
            rdata_r     <= 16'h0000;
            irq_r       <= 1'b0;
            trap_r      <= 1'b0;
            p_rd_r <= 1'b0;
            p_wr_r <= 1'b0;
            d_rd_r <= 1'b0;
            d_wr_r <= 1'b0;
            a_rd_r <= 1'b0;
            a_wr_r <= 1'b0;
            maddr_r  <= 16'h0000;
            mwdata_r <= 16'h0000;
        end else begin
            channel_control_r         <= channel_control_nxt;
            primary_start_address_r   <= primary_start_address_nxt;
            secondary_start_address_r <= secondary_start_address_nxt;
            peripheral_address_r      <= peripheral_address_nxt;
            transfer_count_r          <= transfer_count_nxt;
            address_error_status_r    <= address_error_status_nxt;
            state_r     <= state_nxt;
            ptr_r       <= ptr_nxt;
            last_addr_r <= last_addr_nxt;
            done_r      <= done_nxt;
            use_b_r     <= use_b_nxt;
            half_sent_r <= half_sent_nxt;
            pend_r      <= pend_nxt;
            force_r     <= force_nxt;
            data_r      <= data_nxt;
            rdata_r     <= rdata_nxt;
            irq_r       <= irq_nxt;
            trap_r      <= trap_nxt;
            p_rd_r <= p_rd_nxt;
            p_wr_r <= p_wr_nxt;
            d_rd_r <= d_rd_nxt;
            d_wr_r <= d_wr_nxt;
            a_rd_r <= a_rd_nxt;
            a_wr_r <= a_wr_nxt;
            maddr_r  <= maddr_nxt;
            mwdata_r <= mwdata_nxt;
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata              = rdata_r;
    assign periph_rd              = p_rd_r;
    assign periph_wr              = p_wr_r;
    assign periph_addr            = peripheral_address_r;
    assign periph_wdata           = data_r;
    assign dpram_rd               = d_rd_r;
    assign dpram_wr               = d_wr_r;
    assign arb_rd                 = a_rd_r;
    assign arb_wr                 = a_wr_r;
    assign mem_addr               = maddr_r;
    assign mem_wdata              = mwdata_r;
    assign mem_byte               = channel_control_r[DMACH_B_SIZE];
    assign channel_interrupt_flag = irq_r;
    assign addr_error_trap        = trap_r;
endmodule

// file: tb/dmach_core_monitor.sv
// port-level assertions for the dma channel core
`timescale 1ns/1ps
module dmach_core_monitor
    import dmach_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        periph_rd,
    input wire logic        periph_wr,
    input wire logic        dpram_rd,
    input wire logic        dpram_wr,
    input wire logic        arb_rd,
    input wire logic        arb_wr,
    input wire logic        arb_gnt,
    input wire logic [15:0] mem_addr,
    input wire logic        channel_interrupt_flag,
    input wire logic        addr_error_trap
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // read data zero outside the cycle after a strobe
    chk_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("register read data outside its cycle");
    chk_one_strobe: assert property ($onehot0({periph_rd, periph_wr, dpram_rd, dpram_wr, arb_rd, arb_wr}))
        else $error("more than one transfer strobe at once");
    // arbiter request must stand unchanged until granted
    chk_arb_hold: assert property ((arb_rd || arb_wr) && !arb_gnt |=> $stable({arb_rd, arb_wr, mem_addr}))
        else $error("arbiter request changed before grant");
    chk_dp_window: assert property (dpram_rd || dpram_wr |-> mem_addr >= DMACH_DP_LO && mem_addr <= DMACH_DP_HI)
        else $error("dual-ported strobe outside its window");
    chk_arb_window: assert property (arb_wr |-> (mem_addr < DMACH_DP_LO || mem_addr > DMACH_DP_HI)
        && mem_addr >= DMACH_RAM_LO && mem_addr <= DMACH_RAM_HI) else $error("arbiter write outside ordinary ram");
    // memory write two cycles after a peripheral read
    chk_wr_source: assert property (dpram_wr || $rose(arb_wr) |-> $past(periph_rd, 2))
        else $error("memory write without peripheral read");
    chk_pwr_source: assert property (periph_wr |-> $past(dpram_rd, 2) || $past(arb_rd, 2)
        || $past(mem_addr, 2) < DMACH_RAM_LO || $past(mem_addr, 2) > DMACH_RAM_HI)
        else $error("peripheral write without memory read");
    chk_irq_pulse: assert property (channel_interrupt_flag |=> !channel_interrupt_flag)
        else $error("interrupt pulse longer than one cycle");
    chk_trap_pulse: assert property (addr_error_trap |=> !addr_error_trap)
        else $error("trap pulse longer than one cycle");
endmodule

bind dmach_core dmach_core_monitor mon (.ref_clk(ref_clk), .nrst(nrst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .periph_rd(periph_rd), .periph_wr(periph_wr), .dpram_rd(dpram_rd), .dpram_wr(dpram_wr), .arb_rd(arb_rd),
    .arb_wr(arb_wr), .arb_gnt(arb_gnt), .mem_addr(mem_addr), .channel_interrupt_flag(channel_interrupt_flag),
    .addr_error_trap(addr_error_trap));

// file: tb/dmach_far_model.sv
// peripheral, dual-ported ram and arbiter model
`timescale 1ns/1ps
module dmach_far_model (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        stall,
    input  wire logic        periph_rd,
    input  wire logic        periph_wr,
    input  wire logic [15:0] periph_addr,
    input  wire logic [15:0] periph_wdata,
    output logic      [15:0] periph_rdata,
    input  wire logic        dpram_rd,
    input  wire logic        dpram_wr,
    input  wire logic        arb_rd,
    input  wire logic        arb_wr,
    output logic             arb_gnt,
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    input  wire logic        mem_byte,
    output logic      [15:0] dpram_rdata,
    output logic      [15:0] arb_rdata,
    output int               n_ev,
    output logic      [15:0] last_addr,
    output logic      [15:0] last_data,
    output logic             last_byte
);
    logic [2:0]  wait_r;
    logic [15:0] junk_r;
    // data follows the address; idle lines show a moving pattern
    assign dpram_rdata  = dpram_rd ? (mem_addr ^ 16'h5A5A) : junk_r;
    assign arb_rdata    = (arb_rd && arb_gnt) ? (mem_addr ^ 16'h5A5A) : junk_r;
    assign periph_rdata = periph_rd ? (periph_addr ^ 16'h1111) : ~junk_r;
    // a stalled arbiter grants after four waits
    assign arb_gnt = (arb_rd || arb_wr) && (!stall || wait_r == 3'h4);
    // count finished elements, memory or peripheral side
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wait_r <= 3'h0;
            junk_r <= 16'hA5C3;
            n_ev   <= 0;
        end else begin
            junk_r <= ~junk_r ^ 16'h0F0F;
            wait_r <= ((arb_rd || arb_wr) && !arb_gnt) ? wait_r + 3'h1 : 3'h0;
            if (dpram_wr || (arb_wr && arb_gnt)) begin
                n_ev      <= n_ev + 1;
                last_addr <= mem_addr;
                last_data <= mem_wdata;
                last_byte <= mem_byte;
            end
            if (dpram_rd || (arb_rd && arb_gnt)) begin
                last_addr <= mem_addr;
            end
            if (periph_wr) begin
                n_ev      <= n_ev + 1;
                last_data <= periph_wdata;
            end
        end
    end
endmodule

// file: tb/testbench.sv
// self-checking bench for the dma channel core
`timescale 1ns/1ps
module testbench;
    import dmach_pkg::*;
    logic        ref_clk    = 1'b0;
    logic        nrst       = 1'b0;
    logic [2:0]  reg_addr   = 3'h0;
    logic [15:0] reg_wdata  = 16'h0000;
    logic        reg_wr     = 1'b0;
    logic        reg_rd     = 1'b0;
    logic        periph_req = 1'b0;
    logic        stall      = 1'b0;
    logic [15:0] reg_rdata, periph_addr, periph_wdata, periph_rdata, mem_addr, mem_wdata;
    logic [15:0] dpram_rdata, arb_rdata, last_addr, last_data;
    logic        periph_rd, periph_wr, dpram_rd, dpram_wr, arb_rd, arb_wr, arb_gnt, mem_byte, irq, trap, last_byte;
    int          n_fail     = 0;
    int          cmp_count  = 0;
    int          n_irq      = 0;
    int          n_trap     = 0;
    int          n_ev;
    always #2.5 ref_clk = ~ref_clk;
    dmach_core uut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(periph_req), .periph_rd(periph_rd), .periph_wr(periph_wr),
        .periph_addr(periph_addr), .periph_wdata(periph_wdata), .periph_rdata(periph_rdata), .dpram_rd(dpram_rd),
        .dpram_wr(dpram_wr), .arb_rd(arb_rd), .arb_wr(arb_wr), .arb_gnt(arb_gnt), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_byte(mem_byte), .dpram_rdata(dpram_rdata), .arb_rdata(arb_rdata),
        .channel_interrupt_flag(irq), .addr_error_trap(trap));
    dmach_far_model far (.ref_clk(ref_clk), .nrst(nrst), .stall(stall), .periph_rd(periph_rd), .periph_wr(periph_wr),
        .periph_addr(periph_addr), .periph_wdata(periph_wdata), .periph_rdata(periph_rdata), .dpram_rd(dpram_rd),
        .dpram_wr(dpram_wr), .arb_rd(arb_rd), .arb_wr(arb_wr), .arb_gnt(arb_gnt), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_byte(mem_byte), .dpram_rdata(dpram_rdata), .arb_rdata(arb_rdata), .n_ev(n_ev),
        .last_addr(last_addr), .last_data(last_data), .last_byte(last_byte));
    // pulse counters, interrupt taken as enabled
    always @(posedge ref_clk) begin
        if (nrst && irq === 1'b1) n_irq++;
        if (nrst && trap === 1'b1) n_trap++;
    end
    task automatic complete_run;
        if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one-cycle strobes; read data checked in the next cycle
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        @(negedge ref_clk);
        chk(reg_rdata, e);
    endtask
    task automatic setup(input logic [15:0] ctrl, input logic [15:0] sta, input logic [15:0] cnt);
        wr(DMACH_REG_CTRL, 16'h0000);
        wr(DMACH_REG_STA, sta);
        wr(DMACH_REG_CNT, cnt);
        wr(DMACH_REG_PAD, 16'h0040);
        wr(DMACH_REG_CTRL, ctrl);
    endtask
    // kind 0 request, 1 manual trigger, 2 wait; at most 60 cycles per element
    task automatic step(input int n, input int kind);
        int e;
        int k;
        repeat (n) begin
            e = n_ev;
            k = 0;
            if (kind == 1) wr(DMACH_REG_FORCE, 16'h0001);
            if (kind == 0) @(posedge ref_clk) periph_req <= 1'b1;
            if (kind == 0) @(posedge ref_clk) periph_req <= 1'b0;
            while (n_ev == e && k < 60) begin
                @(posedge ref_clk);
                k++;
            end
            repeat (4) @(posedge ref_clk);
        end
    endtask
    initial begin
        #100000;
        n_fail++;
        complete_run();
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(DMACH_REG_CTRL, 16'h0000);
        rd(DMACH_REG_STAT, 16'h0000);
        setup(16'h8000, 16'hD000, 16'h0002);
        step(2, 0);
        rd(DMACH_REG_STA, 16'hD002);
        step(1, 0);
        chk(last_addr, 16'hD004);
        chk(last_data, 16'h1151);
        chk(16'(n_irq), 16'h0001);
        step(1, 0);
        chk(last_addr, 16'hD000);
        setup(16'hC000, 16'hD001, 16'h0001);
        step(2, 0);
        chk(last_addr, 16'hD002);
        chk({15'h0000, last_byte}, 16'h0001);
        setup(16'hA010, 16'hD008, 16'h0001);
        step(2, 0);
        chk(last_addr, 16'hD008);
        chk(last_data, 16'h8A52);
        chk(16'(n_irq), 16'h0003);
        // half-block interrupts, then half cleared mid-block
        setup(16'h9000, 16'hD000, 16'h0003);
        step(1, 0);
        chk(16'(n_irq), 16'h0003);
        step(1, 0);
        chk(16'(n_irq), 16'h0004);
        step(4, 0);
        chk(16'(n_irq), 16'h0005);
        wr(DMACH_REG_CTRL, 16'h8000);
        step(2, 0);
        chk(16'(n_irq), 16'h0006);
        // single element by manual trigger, count zero
        setup(16'h8000, 16'hD000, 16'h0000);
        step(1, 1);
        chk(16'(n_irq), 16'h0007);
        // ordinary ram through a stalling arbiter, both directions
        stall <= 1'b1;
        setup(16'h8000, 16'h2000, 16'h0000);
        step(1, 0);
        chk(last_addr, 16'h2000);
        setup(16'hA000, 16'h2000, 16'h0000);
        step(1, 0);
        chk(last_data, 16'h7A5A);
        stall <= 1'b0;
        // outside ram: write dropped, read gives zero
        setup(16'h8000, 16'h0800, 16'h0000);
        step(1, 0);
        chk(16'(n_ev), 16'h0013);
        setup(16'hA000, 16'h0800, 16'h0000);
        step(1, 0);
        chk(last_data, 16'h0000);
        setup(16'h8000, 16'hE000, 16'h0000);
        step(1, 0);
        chk(16'(n_trap), 16'h0001);
        rd(DMACH_REG_STAT, 16'h0001);
        wr(DMACH_REG_STAT, 16'h0001);
        rd(DMACH_REG_STAT, 16'h0000);
        // request held pending while disabled
        setup(16'h0000, 16'hD000, 16'h0000);
        step(1, 0);
        chk(16'(n_ev), 16'h0014);
        wr(DMACH_REG_CTRL, 16'h8000);
        step(1, 2);
        chk(16'(n_ev), 16'h0015);
        // one-shot ping-pong switches to the secondary buffer
        wr(DMACH_REG_STB, 16'hD010);
        setup(16'h8003, 16'hD000, 16'h0000);
        step(1, 0);
        rd(DMACH_REG_CTRL, 16'h0003);
        rd(DMACH_REG_STAT, 16'h0002);
        wr(DMACH_REG_CTRL, 16'h8003);
        step(1, 0);
        chk(last_addr, 16'hD010);
        complete_run();
    end
endmodule
